//--- src/pmcb_command_bank.sv
// Command register bank with pin-function and enable logic
`timescale 1ns/100ps
`default_nettype none

module pmcb_command_bank #(
    // Arbitrary designation; top bit set marks an isolated unit
    parameter logic [5:0] MODULE_NAME  = 6'b100001,
    // Arbitrary revision, one decimal digit per nibble
    parameter logic [15:0] FW_REVISION = 16'h0100,
    parameter logic        DROOP_OPTION = 1'b0
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    // Decoded command from the bus protocol layer
    input  wire logic                  reqValid,
    input  wire pmcb_pkg::pmcb_req_t   req,
    output pmcb_pkg::pmcb_rsp_t        rsp,
    // Telemetry and status from the converter core
    input  wire pmcb_pkg::pmcb_tele_t  tele,
    input  wire logic                  outputOk,
    input  wire logic                  smbAlertActive,
    // Pins
    input  wire logic                  primaryOnPin,
    input  wire logic                  pinOneIn,
    input  wire logic                  pinTwoIn,
    output logic                       pinTwoOut,
    output logic                       pinTwoOe,
    // Control outputs
    output logic                       trimEnable,
    output logic                       araOnly,
    output logic                       outputEnable,
    output logic                       writeLock,
    output pmcb_pkg::pmcb_cal_t        cal,
    output pmcb_pkg::pmcb_loop_t       loopCoef,
    output logic [95:0]                serialBlock
);
    import pmcb_pkg::*;

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    logic [7:0]  commFault_reg;
    logic [7:0]  commFault_next;
    logic        lock_reg;
    pmcb_cal_t   cal_reg;
    logic [7:0]  pinCfg_reg;
    logic [7:0]  enLogic_reg;
    logic [7:0]  okPol_reg;
    pmcb_loop_t  loop_reg;
    logic [95:0] serial_reg;
    pmcb_rsp_t   rsp_reg;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    logic        known;
    logic        writable;
    logic        locked;
    logic        dataOk;
    logic [3:0]  expBytes;
    logic [95:0] rdVal;
    logic [15:0] wrWord;
    logic [7:0]  wrByte;
    logic        gainOk;
    logic [4:0]  wrExp;

    assign wrWord = req.data[15:0];
    assign wrByte = req.data[7:0];
    assign wrExp  = wrWord[EXP_LSB +: 5];
    assign gainOk = (wrWord >= GAIN_MIN) && (wrWord <= GAIN_MAX);

    always_comb
    begin
        known    = 1'b1;
        writable = 1'b1;
        locked   = 1'b0;
        dataOk   = 1'b1;
        expBytes = BYTES_WORD;
        rdVal    = '0;
        if (req.code == CMD_COMM_FAULT)
        begin
            expBytes = BYTES_BYTE;
            rdVal    = {88'h0, commFault_reg};
        end
        else if (req.code == CMD_INPUT_VOLTAGE_READING)
        begin
            writable = 1'b0;
            rdVal    = {80'h0, tele.inVolt};
        end
        else if (req.code == CMD_READ_VOUT)
        begin
            writable = 1'b0;
            rdVal    = {80'h0, tele.outVolt};
        end
        else if (req.code == CMD_OUTPUT_CURRENT_READING)
        begin
            writable = 1'b0;
            rdVal    = {80'h0, tele.outCurrent};
        end
        else if (req.code == CMD_READ_TEMP)
        begin
            writable = 1'b0;
            rdVal    = {80'h0, tele.temperature};
        end
        else if (req.code == CMD_MODULE_TYPE)
        begin
            rdVal = {80'h0, 8'h00, MODULE_NAME, lock_reg, 1'b0};
        end
        else if (req.code == CMD_VOUT_GAIN)
        begin
            locked = lock_reg;
            dataOk = gainOk;
            rdVal  = {80'h0, cal_reg.outVoltGain};
        end
        else if (req.code == CMD_VOUT_OFFSET)
        begin
            locked = lock_reg;
            dataOk = (wrExp == EXP_VOUT);
            rdVal  = {80'h0, cal_reg.outVoltOffset};
        end
        else if (req.code == CMD_VIN_GAIN)
        begin
            locked = lock_reg;
            dataOk = gainOk;
            rdVal  = {80'h0, cal_reg.inVoltGain};
        end
        else if (req.code == CMD_VIN_OFFSET)
        begin
            locked = lock_reg;
            dataOk = (wrExp == EXP_VIN);
            rdVal  = {80'h0, cal_reg.inVoltOffset};
        end
        else if (req.code == CMD_IOUT_GAIN)
        begin
            locked = lock_reg;
            dataOk = gainOk;
            rdVal  = {80'h0, cal_reg.outCurrentGain};
        end
        else if (req.code == CMD_IOUT_OFFSET)
        begin
            locked = lock_reg;
            dataOk = (wrExp == EXP_IOUT);
            rdVal  = {80'h0, cal_reg.outCurrentOffset};
        end
        else if (req.code == CMD_FW_REV)
        begin
            writable = 1'b0;
            rdVal    = {80'h0, FW_REVISION};
        end
        else if (req.code == CMD_PIN_CONFIG)
        begin
            expBytes = BYTES_BYTE;
            // Only the three documented roles; droop builds allow the first only
            dataOk   = DROOP_OPTION ? (wrByte[3:0] == ROLE_ONOFF_OK)
                                    : (wrByte[3:0] <= ROLE_TRIM_ONOFF);
            rdVal    = {88'h0, pinCfg_reg};
        end
        else if (req.code == CMD_ENABLE_LOGIC)
        begin
            expBytes = BYTES_BYTE;
            rdVal    = {88'h0, enLogic_reg};
        end
        else if (req.code == CMD_OK_POLARITY)
        begin
            expBytes = BYTES_BYTE;
            rdVal    = {88'h0, okPol_reg};
        end
        else if (req.code == CMD_COEF_P)
        begin
            rdVal = {80'h0, loop_reg.proportional};
        end
        else if (req.code == CMD_COEF_I)
        begin
            rdVal = {80'h0, loop_reg.integral};
        end
        else if (req.code == CMD_COEF_D)
        begin
            rdVal = {80'h0, loop_reg.differential};
        end
        else if (req.code == CMD_COEF_ALPHA)
        begin
            dataOk = ($signed(wrWord) >= $signed(ALPHA_MIN))
                  && ($signed(wrWord) <= $signed(ALPHA_MAX));
            rdVal  = {80'h0, loop_reg.alpha};
        end
        else if (req.code == CMD_SERIAL)
        begin
            expBytes = BYTES_SERIAL;
            locked   = lock_reg;
            rdVal    = serial_reg;
        end
        else
        begin
            known = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Classification of the request
    // ---------------------------------------------------------------
    logic accepted;
    logic badCmd;
    logic badData;
    logic doWrite;

    assign accepted = reqValid && !req.checksumBad;
    assign badCmd   = accepted && (!known || (req.write && !writable));
    assign badData  = accepted && known && req.write && writable
                   && ((req.byteCount != expBytes) || !dataOk || locked);
    assign doWrite  = accepted && known && req.write && writable && !badData;

    // ---------------------------------------------------------------
    // Comm fault byte
    // ---------------------------------------------------------------
    logic [7:0] faultSet;
    logic [7:0] faultClr;

    always_comb
    begin
        faultSet = 8'h00;
        faultSet[CML_BAD_CMD_BIT]  = badCmd;
        faultSet[CML_BAD_DATA_BIT] = badData;
        faultSet[CML_CHECKSUM_BIT] = reqValid && req.checksumBad;
        faultClr = (doWrite && req.code == CMD_COMM_FAULT) ? (wrByte & CML_SUPPORTED) : 8'h00;
        // A fault landing in the clearing cycle survives the clear
        commFault_next = (commFault_reg & ~faultClr) | faultSet;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            commFault_reg <= CML_RESET;
        else
            commFault_reg <= commFault_next;
    end

    // ---------------------------------------------------------------
    // Protection, calibration and serial block
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            lock_reg <= LOCK_RESET;
        else if (doWrite && req.code == CMD_MODULE_TYPE)
            lock_reg <= wrByte[TYPE_LOCK_BIT];
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cal_reg <= '{GAIN_RESET, VOUT_OFS_RESET, GAIN_RESET, VIN_OFS_RESET, GAIN_RESET, IOUT_OFS_RESET};
        end
        else if (doWrite)
        begin
            // Lock and range checks already folded into doWrite
            if (req.code == CMD_VOUT_GAIN)
                cal_reg.outVoltGain <= wrWord;
            else if (req.code == CMD_VOUT_OFFSET)
                cal_reg.outVoltOffset <= wrWord;
            else if (req.code == CMD_VIN_GAIN)
                cal_reg.inVoltGain <= wrWord;
            else if (req.code == CMD_VIN_OFFSET)
                cal_reg.inVoltOffset <= wrWord;
            else if (req.code == CMD_IOUT_GAIN)
                cal_reg.outCurrentGain <= wrWord;
            else if (req.code == CMD_IOUT_OFFSET)
                cal_reg.outCurrentOffset <= wrWord;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            serial_reg <= SERIAL_RESET;
        else if (doWrite && req.code == CMD_SERIAL)
            serial_reg <= req.data;
    end

    // ---------------------------------------------------------------
    // Pin and enable configuration
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pinCfg_reg  <= PIN_CFG_RESET;
            enLogic_reg <= LOGIC_RESET;
            okPol_reg   <= OK_POL_RESET;
        end
        else if (doWrite)
        begin
            if (req.code == CMD_PIN_CONFIG)
                pinCfg_reg <= wrByte & PIN_CFG_MASK;
            else if (req.code == CMD_ENABLE_LOGIC)
                enLogic_reg <= wrByte & LOGIC_MASK;
            else if (req.code == CMD_OK_POLARITY)
                okPol_reg <= wrByte & OK_POL_MASK;
        end
    end

    // ---------------------------------------------------------------
    // Compensation coefficients
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            loop_reg <= '{COEF_RESET, COEF_RESET, COEF_RESET, COEF_RESET};
        end
        else if (doWrite)
        begin
            if (req.code == CMD_COEF_P)
                loop_reg.proportional <= wrWord;
            else if (req.code == CMD_COEF_I)
                loop_reg.integral <= wrWord;
            else if (req.code == CMD_COEF_D)
                loop_reg.differential <= wrWord;
            else if (req.code == CMD_COEF_ALPHA)
                loop_reg.alpha <= wrWord;
        end
    end

    // ---------------------------------------------------------------
    // Response
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rsp_reg <= '0;
        end
        else
        begin
            rsp_reg.valid     <= reqValid;
            rsp_reg.refused   <= reqValid && (req.checksumBad || badCmd || badData);
            rsp_reg.byteCount <= (accepted && known) ? expBytes : 4'd0;
            // Unknown commands and writes answer with zero data
            rsp_reg.data      <= (accepted && !req.write) ? rdVal : '0;
        end
    end

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] pinMeta_reg;
    logic [2:0] pinSync_reg;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pinMeta_reg <= 3'h0;
            pinSync_reg <= 3'h0;
        end
        else
        begin
            pinMeta_reg <= {primaryOnPin, pinOneIn, pinTwoIn};
            pinSync_reg <= pinMeta_reg;
        end
    end

    // ---------------------------------------------------------------
    // Pin roles, enable combination and output-ok drive
    // ---------------------------------------------------------------
    logic [3:0] role;
    logic       secondaryRaw;
    logic       secondaryOn;
    logic       primaryOn;
    logic       okPinOwned;

    assign role         = pinCfg_reg[3:0];
    assign primaryOn    = pinSync_reg[2];
    // Secondary input lives on pin two only in the trim/onoff role
    assign secondaryRaw = (role == ROLE_TRIM_ONOFF) ? pinSync_reg[0] : pinSync_reg[1];
    assign secondaryOn  = enLogic_reg[LOGIC_POL_BIT] ? secondaryRaw : !secondaryRaw;
    assign okPinOwned   = (role == ROLE_ONOFF_OK) || (role == ROLE_TRIM_OK);

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            outputEnable <= 1'b0;
            pinTwoOut    <= 1'b0;
            pinTwoOe     <= 1'b0;
            trimEnable   <= 1'b0;
            araOnly      <= 1'b0;
        end
        else
        begin
            // Trim/ok role has no secondary input, so the AND mode then follows the primary alone
            outputEnable <= primaryOn && (!enLogic_reg[LOGIC_AND_BIT] || role == ROLE_TRIM_OK
                                          || secondaryOn);
            pinTwoOut    <= okPol_reg[OK_POL_BIT] ? outputOk : !outputOk;
            pinTwoOe     <= okPinOwned;
            trimEnable   <= (role == ROLE_TRIM_OK) || (role == ROLE_TRIM_ONOFF);
            araOnly      <= pinCfg_reg[PIN_ARA_BIT] && smbAlertActive;
        end
    end

    assign rsp         = rsp_reg;
    assign writeLock   = lock_reg;
    assign cal         = cal_reg;
    assign loopCoef    = loop_reg;
    assign serialBlock = serial_reg;

endmodule : pmcb_command_bank

`default_nettype wire

//--- src/pmcb_pkg.sv
// Constants, field layout and carrier types of the power module command bank
package pmcb_pkg;

    // ---------------------------------------------------------------
    // Command codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_COMM_FAULT  = 8'h7E;
    localparam logic [7:0] CMD_INPUT_VOLTAGE_READING    = 8'h88;
    localparam logic [7:0] CMD_READ_VOUT   = 8'h8B;
    localparam logic [7:0] CMD_OUTPUT_CURRENT_READING   = 8'h8C;
    localparam logic [7:0] CMD_READ_TEMP   = 8'h8D;
    localparam logic [7:0] CMD_MODULE_TYPE = 8'hD0;
    localparam logic [7:0] CMD_VOUT_GAIN   = 8'hD1;
    localparam logic [7:0] CMD_VOUT_OFFSET = 8'hD2;
    localparam logic [7:0] CMD_VIN_GAIN    = 8'hD3;
    localparam logic [7:0] CMD_VIN_OFFSET  = 8'hD4;
    localparam logic [7:0] CMD_IOUT_GAIN   = 8'hD6;
    localparam logic [7:0] CMD_IOUT_OFFSET = 8'hD7;
    localparam logic [7:0] CMD_FW_REV      = 8'hDB;
    localparam logic [7:0] CMD_PIN_CONFIG  = 8'hE0;
    localparam logic [7:0] CMD_ENABLE_LOGIC = 8'hE1;
    localparam logic [7:0] CMD_OK_POLARITY = 8'hE2;
    localparam logic [7:0] CMD_COEF_P      = 8'hE3;
    localparam logic [7:0] CMD_COEF_I      = 8'hE4;
    localparam logic [7:0] CMD_COEF_D      = 8'hE5;
    localparam logic [7:0] CMD_COEF_ALPHA  = 8'hE6;
    localparam logic [7:0] CMD_SERIAL      = 8'hF0;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CML_BAD_CMD_BIT  = 7;
    localparam int CML_BAD_DATA_BIT = 6;
    localparam int CML_CHECKSUM_BIT = 5;
    localparam int TYPE_LOCK_BIT    = 1;
    localparam int TYPE_NAME_LSB    = 2;
    localparam int PIN_ARA_BIT      = 4;
    localparam int LOGIC_AND_BIT    = 1;
    localparam int LOGIC_POL_BIT    = 0;
    localparam int OK_POL_BIT       = 0;
    localparam int EXP_LSB          = 11;

    localparam logic [7:0] CML_SUPPORTED  = 8'hE0;
    localparam logic [3:0] ROLE_ONOFF_OK  = 4'h0;
    localparam logic [3:0] ROLE_TRIM_OK   = 4'h1;
    localparam logic [3:0] ROLE_TRIM_ONOFF = 4'h2;
    localparam logic [7:0] PIN_CFG_MASK   = 8'h1F;
    localparam logic [7:0] LOGIC_MASK     = 8'h03;
    localparam logic [7:0] OK_POL_MASK    = 8'h01;

    // ---------------------------------------------------------------
    // Ranges, exponents and transfer sizes
    // ---------------------------------------------------------------
    localparam logic [15:0] GAIN_MIN     = 16'h1999;
    localparam logic [15:0] GAIN_MAX     = 16'h2666;
    localparam logic [4:0]  EXP_VOUT     = 5'h14;
    localparam logic [4:0]  EXP_VIN      = 5'h1D;
    localparam logic [4:0]  EXP_IOUT     = 5'h1C;
    localparam logic [15:0] ALPHA_MIN    = 16'hFF00;
    localparam logic [15:0] ALPHA_MAX    = 16'h00FF;
    localparam logic [3:0]  BYTES_BYTE   = 4'd1;
    localparam logic [3:0]  BYTES_WORD   = 4'd2;
    localparam logic [3:0]  BYTES_SERIAL = 4'd12;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0]  CML_RESET       = 8'h00;
    localparam logic        LOCK_RESET      = 1'b1;
    localparam logic [15:0] GAIN_RESET      = 16'h2000;
    localparam logic [15:0] VOUT_OFS_RESET  = 16'hA000;
    localparam logic [15:0] VIN_OFS_RESET   = 16'hE800;
    localparam logic [15:0] IOUT_OFS_RESET  = 16'hE000;
    localparam logic [7:0]  PIN_CFG_RESET   = 8'h00;
    localparam logic [7:0]  LOGIC_RESET     = 8'h00;
    localparam logic [7:0]  OK_POL_RESET    = 8'h01;
    localparam logic [15:0] COEF_RESET      = 16'h0000;
    localparam logic [95:0] SERIAL_RESET    = 96'h0000_0000_0000_0000_0000_0000;

    // ---------------------------------------------------------------
    // Carrier types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        write;
        logic        checksumBad;
        logic [7:0]  code;
        logic [3:0]  byteCount;
        logic [95:0] data;
    } pmcb_req_t;

    typedef struct packed {
        logic        valid;
        logic        refused;
        logic [3:0]  byteCount;
        logic [95:0] data;
    } pmcb_rsp_t;

    typedef struct packed {
        logic [15:0] inVolt;
        logic [15:0] outVolt;
        logic [15:0] outCurrent;
        logic [15:0] temperature;
    } pmcb_tele_t;

    typedef struct packed {
        logic [15:0] outVoltGain;
        logic [15:0] outVoltOffset;
        logic [15:0] inVoltGain;
        logic [15:0] inVoltOffset;
        logic [15:0] outCurrentGain;
        logic [15:0] outCurrentOffset;
    } pmcb_cal_t;

    typedef struct packed {
        logic [15:0] proportional;
        logic [15:0] integral;
        logic [15:0] differential;
        logic [15:0] alpha;
    } pmcb_loop_t;

endpackage : pmcb_pkg

//--- testbench/pmcb_host_model.sv
// Host model issuing decoded commands to the bank
`timescale 1ns/100ps
`default_nettype none
module pmcb_host_model
    import pmcb_pkg::*;
(
    // Command port
    input  wire logic       mclk,
    output logic            reqValid,
    output pmcb_req_t       req,
    input  wire pmcb_rsp_t  rsp
);
    // ----------------
    // Transfers
    // ----------------
    initial
    begin
        reqValid = 1'b0;
        req = '0;
    end
    // Droop builds are never sent a role other than 0000
    task automatic xfer(input pmcb_req_t r, output pmcb_rsp_t a);
        @(negedge mclk);
        req = r;
        reqValid = 1'b1;
        @(negedge mclk);
        a = rsp;
        reqValid = 1'b0;
        // Idle bus shows no stale value
        req = ~r;
    endtask : xfer
endmodule : pmcb_host_model
`default_nettype wire

//--- testbench/pmcb_command_bank_sva.sv
// Port assertions of the command bank
`timescale 1ns/100ps
`default_nettype none
module pmcb_command_bank_sva
    import pmcb_pkg::*;
(
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       reqValid,
    input wire pmcb_req_t  req,
    input wire pmcb_rsp_t  rsp,
    input wire pmcb_tele_t tele,
    input wire logic       smbAlertActive,
    input wire logic       pinTwoOe,
    input wire logic       trimEnable,
    input wire logic       araOnly,
    input wire logic       writeLock
);
    // ----------------
    // Assertions
    // ----------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    wire logic rd = reqValid && !req.write && !req.checksumBad;
    wire logic wr = reqValid && req.write && !req.checksumBad;
    property p_ans; 1 |=> rsp.valid == $past(reqValid); endproperty
    a_ans: assert property (p_ans) else $error("answer pulse wrong");
    property p_pec; reqValid && req.checksumBad |=> rsp.refused; endproperty
    a_pec: assert property (p_pec) else $error("bad checksum taken");
    property p_tel; rd && req.code == CMD_OUTPUT_CURRENT_READING |=> rsp.data[15:0] == $past(tele.outCurrent); endproperty
    a_tel: assert property (p_tel) else $error("current reading wrong");
    property p_rev; wr && req.code == CMD_FW_REV |=> rsp.refused; endproperty
    a_rev: assert property (p_rev) else $error("revision written");
    property p_lck; wr && writeLock && req.code == CMD_SERIAL |=> rsp.refused; endproperty
    a_lck: assert property (p_lck) else $error("locked block written");
    property p_gan; wr && req.code == CMD_VIN_GAIN && req.data[15:0] < GAIN_MIN |=> rsp.refused; endproperty
    a_gan: assert property (p_gan) else $error("low gain taken");
    property p_ara; araOnly |-> $past(smbAlertActive); endproperty
    a_ara: assert property (p_ara) else $error("alert address without alert");
    property p_rol; $past(nrst) |-> trimEnable || pinTwoOe; endproperty
    a_rol: assert property (p_rol) else $error("no pin role");
    property p_blk; rd && req.code == CMD_SERIAL |=> rsp.byteCount == BYTES_SERIAL; endproperty
    a_blk: assert property (p_blk) else $error("block size wrong");
endmodule : pmcb_command_bank_sva
bind pmcb_command_bank pmcb_command_bank_sva chk_u (.mclk, .nrst, .reqValid, .req, .rsp, .tele,
    .smbAlertActive, .pinTwoOe, .trimEnable, .araOnly, .writeLock);
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench of the command bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pmcb_pkg::*;
    // ----------------
    // Bench
    // ----------------
    localparam logic [5:0]  NAME = 6'b100001; // arbitrary designation
    localparam logic [15:0] FW   = 16'h0100;  // arbitrary revision
    logic        mclk = 1'b0, nrst = 1'b0, reqValid, outputOk = 1'b1, smbAlertActive = 1'b0;
    logic        primaryOnPin = 1'b1, pinOneIn = 1'b0, pinTwoIn = 1'b0, pinTwoOut, pinTwoOe, trimEnable, araOnly;
    logic        outputEnable, writeLock;
    pmcb_loop_t  lc;
    pmcb_req_t   req;
    pmcb_rsp_t   rsp;
    pmcb_tele_t  tele;
    int          error_cnt = 0, checks_done = 0, cyc = 0;
    int          wv [] = '{'h2D32100, 'h2D31998, 'h2D11999, 'h1D12000, 'h2D32666, 'h2D62667, 'h2D2A123, 'h2D21234,
                          'h2D4E9FF, 'h2D7E001, 'h2E38000, 'h2E47FFF, 'h2E600FF, 'h2E60100, 'h2E6FF00, 'h2E6FEFF,
                          'h1E00011, 'h1E00003, 'h1E00010, 'h1E100FF, 'h1E20000};
    logic [31:0] rng = 32'd86;
    logic [95:0] mdl [int];
    pmcb_command_bank #(.MODULE_NAME(NAME), .FW_REVISION(FW)) dut_u (.mclk, .nrst, .reqValid, .req, .rsp, .tele,
        .outputOk, .smbAlertActive, .primaryOnPin, .pinOneIn, .pinTwoIn, .pinTwoOut, .pinTwoOe, .trimEnable,
        .araOnly, .outputEnable, .writeLock, .cal(), .loopCoef(lc), .serialBlock());
    pmcb_host_model host_u (.mclk, .reqValid, .req, .rsp);
    always #25 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            error_cnt++;
            test_done();
        end
    end
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    task automatic cmp(input string nm, input logic [95:0] got, input logic [95:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : cmp
    // Reference model: fault byte in mdl[7E], lock in mdl[D0] bit 1
    task automatic op(input logic w, input logic [7:0] c, input logic [3:0] n, input logic [95:0] d,
                      input logic bad = 1'b0);
        logic [7:0]  f;
        logic [3:0]  s;
        logic [95:0] v;
        pmcb_rsp_t   a;
        f = bad ? 8'h20 : 8'h00;
        s = (c inside {8'h7E, [8'hE0:8'hE2]}) ? 4'd1 : (c == 8'hF0) ? 4'd12 : 4'd2;
        v = mdl.exists(c) ? mdl[c] : '0;
        if (!bad && (!mdl.exists(c) || w && c inside {[8'h88:8'h8D], 8'hDB}))
            f = 8'h80;
        else if (!bad && w && (n != s || c inside {8'hD1, 8'hD3, 8'hD6} && (d[15:0] < 16'h1999 || d[15:0] > 16'h2666)
                 || c == 8'hD2 && d[15:11] != EXP_VOUT || c == 8'hD4 && d[15:11] != EXP_VIN
                 || c == 8'hD7 && d[15:11] != EXP_IOUT || c == 8'hE6 && !(d[15:8] inside {8'h00, 8'hFF})
                 || c == 8'hE0 && d[3:0] > 4'h2 || mdl[8'hD0][1] && c inside {[8'hD1:8'hD4], 8'hD6, 8'hD7, 8'hF0}))
            f = 8'h40;
        mdl[8'h7E][7:0] = mdl[8'h7E][7:0] | f;
        if (w && f == 8'h00)
            case (c)
                8'h7E: mdl[c][7:0] = mdl[c][7:0] & ~(d[7:0] & 8'hE0);
                8'hD0: mdl[c][1] = d[1];
                8'hE0: mdl[c] = d & 96'h1F;
                8'hE1: mdl[c] = d & 96'h03;
                8'hE2: mdl[c] = d & 96'h01;
                default: mdl[c] = (c == 8'hF0) ? d : {80'h0, d[15:0]};
            endcase
        host_u.xfer({w, bad, c, n, d}, a);
        cmp("refused", a.refused, f != 8'h00);
        if (!w && f == 8'h00)
        begin
            cmp("data", a.data, v);
            cmp("count", a.byteCount, s);
        end
    endtask : op
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    initial
    begin
        tele = {rnd(), rnd()};
        mdl = '{'h7E: 0, 'h88: tele.inVolt, 'h8B: tele.outVolt, 'h8C: tele.outCurrent, 'h8D: tele.temperature,
                'hD0: {NAME, 2'b10}, 'hD1: 'h2000, 'hD2: 'hA000, 'hD3: 'h2000, 'hD4: 'hE800, 'hD6: 'h2000,
                'hD7: 'hE000, 'hDB: FW, 'hE0: 0, 'hE1: 0, 'hE2: 1, 'hE3: 0, 'hE4: 0, 'hE5: 0, 'hE6: 0, 'hF0: 0};
        repeat (4) @(negedge mclk);
        nrst = 1'b1;
        foreach (mdl[k]) op(1'b0, 8'(k), 4'd2, '0);
        $display("test reset values done");
        op(1'b1, 8'hD1, 4'd2, 96'h2100);
        op(1'b1, 8'h8B, 4'd2, 96'h0);
        op(1'b1, 8'hDB, 4'd2, 96'h9999);
        op(1'b0, 8'h99, 4'd2, 96'h0);
        op(1'b0, 8'hE3, 4'd2, 96'h0, 1'b1);
        op(1'b1, 8'h7E, 4'd1, 96'h60);
        op(1'b0, 8'h7E, 4'd1, 96'h0);
        op(1'b1, 8'hD0, 4'd2, 96'hFFFD);
        op(1'b0, 8'hD0, 4'd2, 96'h0);
        $display("test faults and lock done");
        foreach (wv[i])
        begin
            op(1'b1, wv[i][23:16], wv[i][27:24], 96'(wv[i][15:0]));
            op(1'b0, wv[i][23:16], 4'd2, '0);
        end
        op(1'b1, 8'hE5, 4'd2, 96'(16'(rnd())));
        op(1'b0, 8'hE5, 4'd2, '0);
        cmp("coef", lc.differential, mdl[8'hE5]);
        op(1'b1, 8'hF0, 4'd12, {rnd(), rnd(), rnd()});
        op(1'b0, 8'hF0, 4'd12, '0);
        op(1'b1, 8'hD0, 4'd2, 96'h2);
        op(1'b1, 8'hF0, 4'd12, {rnd(), rnd(), rnd()});
        op(1'b0, 8'hF0, 4'd12, '0);
        $display("test value checks done");
        smbAlertActive = 1'b1;
        repeat (4) @(negedge mclk);
        cmp("ara", araOnly, 1'b1);
        cmp("enable", outputEnable, 1'b0);
        cmp("okpin", pinTwoOut, 1'b0);
        cmp("oe", pinTwoOe, 1'b1);
        pinOneIn = 1'b1;
        repeat (4) @(negedge mclk);
        cmp("enable", outputEnable, 1'b1);
        op(1'b1, 8'hE0, 4'd1, 96'h2);
        repeat (4) @(negedge mclk);
        cmp("roles", {trimEnable, pinTwoOe, outputEnable}, 3'b100);
        pinTwoIn = 1'b1;
        repeat (4) @(negedge mclk);
        cmp("enable", outputEnable, 1'b1);
        $display("test pins done");
        test_done();
    end
endmodule : tb
`default_nettype wire
